// ==== common/arm_pkg.sv ====
// Shared constants and carrier types for the address remap block
package arm_pkg;
  // ==========================================================
  // Header constants
  localparam logic [7:0] CAP_ID = 8'h08;
  localparam logic [4:0] CAP_TYPE = 5'h14;
  localparam logic [1:0] MAP_40 = 2'h0;
  localparam logic [1:0] MAP_64 = 2'h1;
  localparam int IO_BITS = 25;
  // ==========================================================
  // Byte offsets (header in both variants; then 40-bit direct, then 64-bit indexed)
  localparam logic [7:0] OFF_HDR = 8'h00;
  localparam logic [7:0] OFF_NP = 8'h04;
  localparam logic [7:0] OFF_PF = 8'h08;
  localparam logic [7:0] OFF_DMA0 = 8'h0C;
  localparam logic [7:0] DMA_STRIDE = 8'h08;
  localparam logic [7:0] OFF_INDEX = 8'h04;
  localparam logic [7:0] OFF_DLO = 8'h08;
  localparam logic [7:0] OFF_DHI = 8'h0C;
  // ==========================================================
  // Indexed register numbers (64-bit variant)
  localparam logic [7:0] IDX_NP = 8'h00;
  localparam logic [7:0] IDX_PF = 8'h01;
  localparam logic [7:0] IDX_PNP = 8'h02;
  localparam logic [1:0] SUB_PBASE = 2'h0;
  localparam logic [1:0] SUB_SBASE = 2'h1;
  localparam logic [1:0] SUB_SLIM = 2'h2;
  // ==========================================================
  // Field positions
  localparam int HDR_PTR_LSB = 8;
  localparam int HDR_CNT_LSB = 16;
  localparam int HDR_IOSZ_LSB = 20;
  localparam int HDR_MAP_LSB = 25;
  localparam int HDR_TYPE_LSB = 27;
  localparam int CTRL_LSB = 28;
  localparam int CTL_EN = 3;
  localparam int CTL_ISO = 2;
  localparam int CTL_RLX = 1;
  localparam int CTL_CMP = 0;
  // ==========================================================
  // Reset values
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [43:0] RST_ADDR = 44'h0;
  localparam logic [4:0] RST_IOSZ = 5'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [3:0] ctrl;
    logic [43:0] base;
  } arm_dwin_t;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [43:0] pbase;
    logic [43:0] sbase;
    logic [43:0] slimit;
  } arm_dma_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } arm_cfg_req_t;
  typedef struct packed {
    logic valid;
    logic is_io;
    logic hit_np;
    logic hit_pf;
    logic [63:0] addr;
    logic [63:0] win_off;
    logic compat;
    logic coherent;
    logic isoc;
  } arm_dn_req_t;
  typedef struct packed {
    logic valid;
    logic in_dn_win;
    logic [63:0] addr;
    logic compat;
    logic coherent;
    logic isoc;
  } arm_up_req_t;
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
    logic compat;
    logic coherent;
    logic isoc;
    logic isoc_vc;
  } arm_req_out_t;
endpackage

// ==== hdl/arm_remap.sv ====
// Address remap capability: config registers plus both remap datapaths
// Functional notes
// RULE1: Header reads ID 08h and a fixed next-capability pointer, 00h if last.
// RULE2: Read-only count field reports implemented upstream window sets.
// RULE3: Writable I/O size drops upper bits of 25-bit I/O address as zeros.
// RULE4: Mapping type reads 0 for 40-bit, 1 for 64-bit variant.
// RULE5: Capability type field reads 10100b.
// RULE6: Every register returns to default on warm reset.
// RULE7: Control nibble: enable 3, isochronous 2, relaxed 1, compat 0 sets compat.
// RULE8: Relaxed flag clears coherent attribute on downstream window requests.
// RULE9: Isochronous flag sets isoc attribute; isoc channel when flow control enabled.
// RULE10: Disabled downstream window applies no mapping or attribute change.
// RULE11: 40-bit window base fields give address bits 39:20.
// RULE12: Upstream window relaxed/isochronous flags clear coherent, set isoc.
// RULE13: Upstream window compared only while its enable is set.
// RULE14: 40-bit primary base gives destination bits 39:24.
// RULE15: Secondary base/limit bound window; hits remap from primary base.
// RULE16: Missing low base bits read as zeros, low limit bits as ones.
// RULE17: Upstream misses pass to primary bus unchanged.
// RULE18: 64-bit variant reaches 64-bit registers through index and two data words.
// RULE19: 64-bit window base lower and upper form bits 63:20; control 3:0.
// RULE20: 64-bit upstream base/limit pairs carry bits 63:20.
// RULE21: 64-bit primary non-prefetchable upper base and limit widen that window.
// RULE22: Variant chosen by parameter; 64-bit bridges use the indexed form.
// RULE23: Hit address is target base plus offset into matched window.
`timescale 1ns/1ps
`default_nettype none
module arm_remap #(
  parameter int NUM_DMA = 4,
  parameter logic [1:0] MAP_TYPE = arm_pkg::MAP_64,
  parameter logic [7:0] NEXT_PTR = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic isoc_fc_en,
  input wire arm_pkg::arm_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvld,
  input wire arm_pkg::arm_dn_req_t dn_req,
  output arm_pkg::arm_req_out_t dn_out,
  input wire arm_pkg::arm_up_req_t up_req,
  output arm_pkg::arm_req_out_t up_out,
  output logic [31:0] pnp_base_upper,
  output logic [31:0] pnp_limit_upper
);
  import arm_pkg::*;

  // ==========================================================
  // Elaboration checks
  // Count field is four bits, so at most fifteen windows
  if (NUM_DMA < 1 || NUM_DMA > 15) begin : g_bad_cnt
    $error("NUM_DMA must lie in 1..15");
  end
  if (MAP_TYPE > MAP_64) begin : g_bad_map
    $error("MAP_TYPE above 1 is reserved");
  end

  localparam bit IS64 = (MAP_TYPE == MAP_64); // RULE22
  localparam logic [3:0] CNT = 4'(NUM_DMA);

  // ==========================================================
  // State
  typedef struct packed {
    arm_dwin_t np;
    arm_dwin_t pf;
    logic [31:0] pnp_bu;
    logic [31:0] pnp_lu;
    arm_dma_t [NUM_DMA-1:0] dma;
    logic [4:0] iosz;
    logic [7:0] index;
    logic [31:0] rdata;
    logic rvld;
    arm_req_out_t dn_o;
    arm_req_out_t up_o;
  } arm_st_t;

  arm_st_t st_ff;
  arm_st_t nxt_st;
  logic [NUM_DMA-1:0] dma_hit;
  logic [NUM_DMA-1:0][63:0] dma_map;

  // Byte-lane merge of a config write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  // ==========================================================
  // Upstream window compare, one copy per window
  // Compare on bits 63:20 only: low base bits act as zeros, low limit bits as ones
  for (genvar n = 0; n < NUM_DMA; n++) begin : g_dma
    assign dma_hit[n] = st_ff.dma[n].ctrl[CTL_EN] && // RULE13
      up_req.addr[63:20] >= st_ff.dma[n].sbase &&
      up_req.addr[63:20] <= st_ff.dma[n].slimit; // RULE15 RULE16
    assign dma_map[n] = {st_ff.dma[n].pbase, 20'h0} +
      (up_req.addr - {st_ff.dma[n].sbase, 20'h0}); // RULE23
  end

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic [31:0] hdr;
    logic [31:0] rw;
    logic [31:0] nw;
    logic [63:0] v64;
    logic [63:0] n64;
    logic sel_hi;
    logic dn_en;
    logic [3:0] dn_ctl;
    logic [43:0] dn_base;
    logic found;
    hdr = '0;
    rw = '0;
    nw = '0;
    v64 = '0;
    n64 = '0;
    sel_hi = 1'b0;
    dn_en = 1'b0;
    dn_ctl = '0;
    dn_base = '0;
    found = 1'b0;
    nxt_st = st_ff;
    nxt_st.rvld = cfg_req.rd;

    // Header word is common to both variants
    hdr[7:0] = CAP_ID; // RULE1
    hdr[HDR_PTR_LSB +: 8] = NEXT_PTR; // RULE1
    hdr[HDR_CNT_LSB +: 4] = CNT; // RULE2
    hdr[HDR_IOSZ_LSB +: 5] = st_ff.iosz; // RULE3
    hdr[HDR_MAP_LSB +: 2] = MAP_TYPE; // RULE4
    hdr[HDR_TYPE_LSB +: 5] = CAP_TYPE; // RULE5

    // ---------------- register read and write ----------------
    if (cfg_req.addr == OFF_HDR)
    begin
      rw = hdr;
      nw = merge(rw, cfg_req.wdata, cfg_req.be);
      if (cfg_req.wr)
        nxt_st.iosz = nw[HDR_IOSZ_LSB +: 5]; // RULE3
    end
    else if (!IS64)
    begin
      // Directly addressed 40-bit layout
      if (cfg_req.addr == OFF_NP || cfg_req.addr == OFF_PF)
      begin
        dn_ctl = (cfg_req.addr == OFF_NP) ? st_ff.np.ctrl : st_ff.pf.ctrl;
        dn_base = (cfg_req.addr == OFF_NP) ? st_ff.np.base : st_ff.pf.base;
        rw = {dn_ctl, 8'h00, dn_base[19:0]}; // RULE11
        nw = merge(rw, cfg_req.wdata, cfg_req.be);
        if (cfg_req.wr && cfg_req.addr == OFF_NP)
          nxt_st.np = {nw[CTRL_LSB +: 4], 24'h0, nw[19:0]}; // RULE7 RULE11
        if (cfg_req.wr && cfg_req.addr == OFF_PF)
          nxt_st.pf = {nw[CTRL_LSB +: 4], 24'h0, nw[19:0]}; // RULE7 RULE11
      end
      for (int n = 0; n < NUM_DMA; n++)
      begin
        if (cfg_req.addr == OFF_DMA0 + 8'(n) * DMA_STRIDE)
        begin
          rw = {st_ff.dma[n].ctrl, 12'h000, st_ff.dma[n].pbase[19:4]}; // RULE14
          nw = merge(rw, cfg_req.wdata, cfg_req.be);
          if (cfg_req.wr)
          begin
            nxt_st.dma[n].ctrl = nw[CTRL_LSB +: 4];
            nxt_st.dma[n].pbase = {24'h0, nw[15:0], 4'h0}; // RULE14 RULE16
          end
        end
        if (cfg_req.addr == OFF_DMA0 + 8'(n) * DMA_STRIDE + 8'h04)
        begin
          rw = {st_ff.dma[n].slimit[19:4], st_ff.dma[n].sbase[19:4]}; // RULE15
          nw = merge(rw, cfg_req.wdata, cfg_req.be);
          if (cfg_req.wr)
          begin
            nxt_st.dma[n].sbase = {24'h0, nw[15:0], 4'h0}; // RULE16
            nxt_st.dma[n].slimit = {24'h0, nw[31:16], 4'hF}; // RULE16
          end
        end
      end
    end
    else if (cfg_req.addr == OFF_INDEX)
    begin
      rw = {24'h0, st_ff.index};
      nw = merge(rw, cfg_req.wdata, cfg_req.be);
      if (cfg_req.wr)
        nxt_st.index = nw[7:0]; // RULE18
    end
    else if (cfg_req.addr == OFF_DLO || cfg_req.addr == OFF_DHI)
    begin
      // Indexed 64-bit layout; unlisted indexes read zero, writes dropped
      sel_hi = (cfg_req.addr == OFF_DHI);
      case (st_ff.index)
        IDX_NP: v64 = {st_ff.np.base, 16'h0, st_ff.np.ctrl}; // RULE19
        IDX_PF: v64 = {st_ff.pf.base, 16'h0, st_ff.pf.ctrl}; // RULE19
        IDX_PNP: v64 = {st_ff.pnp_lu, st_ff.pnp_bu}; // RULE21
        default: v64 = '0;
      endcase
      for (int n = 0; n < NUM_DMA; n++)
      begin
        if (st_ff.index[7:2] == 6'(n + 1))
        begin
          case (st_ff.index[1:0])
            SUB_PBASE: v64 = {st_ff.dma[n].pbase, 16'h0, st_ff.dma[n].ctrl}; // RULE20
            SUB_SBASE: v64 = {st_ff.dma[n].sbase, 20'h0}; // RULE20
            SUB_SLIM: v64 = {st_ff.dma[n].slimit, 20'h0}; // RULE20
            default: v64 = '0;
          endcase
        end
      end
      rw = sel_hi ? v64[63:32] : v64[31:0]; // RULE18
      nw = merge(rw, cfg_req.wdata, cfg_req.be);
      n64 = sel_hi ? {nw, v64[31:0]} : {v64[63:32], nw};
      if (cfg_req.wr)
      begin
        case (st_ff.index)
          // Control nibble sits above the base in the carrier, unlike the register word
          IDX_NP: nxt_st.np = {n64[3:0], n64[63:20]}; // RULE19
          IDX_PF: nxt_st.pf = {n64[3:0], n64[63:20]}; // RULE19
          IDX_PNP:
          begin
            nxt_st.pnp_bu = n64[31:0]; // RULE21
            nxt_st.pnp_lu = n64[63:32]; // RULE21
          end
          default: nxt_st.index = st_ff.index;
        endcase
        for (int n = 0; n < NUM_DMA; n++)
        begin
          if (st_ff.index[7:2] == 6'(n + 1))
          begin
            case (st_ff.index[1:0])
              SUB_PBASE:
              begin
                nxt_st.dma[n].pbase = n64[63:20]; // RULE20
                nxt_st.dma[n].ctrl = n64[3:0];
              end
              SUB_SBASE: nxt_st.dma[n].sbase = n64[63:20]; // RULE20
              SUB_SLIM: nxt_st.dma[n].slimit = n64[63:20]; // RULE20
              default: nxt_st.index = st_ff.index;
            endcase
          end
        end
      end
    end
    if (cfg_req.rd)
      nxt_st.rdata = rw;

    // ---------------- downstream path ----------------
    // Window hit comes from the bridge decoder; prefetchable wins a double hit
    dn_ctl = dn_req.hit_pf ? st_ff.pf.ctrl : st_ff.np.ctrl;
    dn_base = dn_req.hit_pf ? st_ff.pf.base : st_ff.np.base;
    dn_en = (dn_req.hit_pf || dn_req.hit_np) && dn_ctl[CTL_EN] && !dn_req.is_io;
    nxt_st.dn_o.valid = dn_req.valid;
    nxt_st.dn_o.addr = dn_req.addr;
    nxt_st.dn_o.compat = dn_req.compat;
    nxt_st.dn_o.coherent = dn_req.coherent;
    nxt_st.dn_o.isoc = dn_req.isoc;
    if (dn_req.is_io)
    begin
      // Dropped high I/O bits go out as zeros
      for (int i = 0; i < 64; i++)
      begin
        if (i >= IO_BITS || i >= IO_BITS - int'(st_ff.iosz))
          nxt_st.dn_o.addr[i] = 1'b0; // RULE3
      end
    end
    else if (dn_en) // RULE10
    begin
      nxt_st.dn_o.addr = {dn_base, 20'h0} + dn_req.win_off; // RULE23
      if (dn_ctl[CTL_CMP])
        nxt_st.dn_o.compat = 1'b1; // RULE7
      if (dn_ctl[CTL_RLX])
        nxt_st.dn_o.coherent = 1'b0; // RULE8
      if (dn_ctl[CTL_ISO])
        nxt_st.dn_o.isoc = 1'b1; // RULE9
    end
    nxt_st.dn_o.isoc_vc = nxt_st.dn_o.isoc && isoc_fc_en; // RULE9

    // ---------------- upstream path ----------------
    // Lowest numbered window wins an overlap
    nxt_st.up_o.valid = up_req.valid;
    nxt_st.up_o.addr = up_req.addr; // RULE17
    nxt_st.up_o.compat = up_req.compat;
    nxt_st.up_o.coherent = up_req.coherent;
    nxt_st.up_o.isoc = up_req.isoc;
    for (int n = 0; n < NUM_DMA; n++)
    begin
      if (!found && dma_hit[n] && !up_req.in_dn_win)
      begin
        found = 1'b1;
        nxt_st.up_o.addr = dma_map[n]; // RULE15
        if (st_ff.dma[n].ctrl[CTL_RLX])
          nxt_st.up_o.coherent = 1'b0; // RULE12
        if (st_ff.dma[n].ctrl[CTL_ISO])
          nxt_st.up_o.isoc = 1'b1; // RULE12
      end
    end
    nxt_st.up_o.isoc_vc = nxt_st.up_o.isoc && isoc_fc_en;
  end

  // ==========================================================
  // State register; warm reset clears every field
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0; // RULE6
      st_ff.np <= {RST_CTRL, RST_ADDR};
      st_ff.pf <= {RST_CTRL, RST_ADDR};
      st_ff.pnp_bu <= RST_WORD;
      st_ff.pnp_lu <= RST_WORD;
      st_ff.iosz <= RST_IOSZ;
      st_ff.index <= RST_INDEX;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign cfg_rdata = st_ff.rdata;
  assign cfg_rvld = st_ff.rvld;
  assign dn_out = st_ff.dn_o;
  assign up_out = st_ff.up_o;
  assign pnp_base_upper = st_ff.pnp_bu; // RULE21
  assign pnp_limit_upper = st_ff.pnp_lu; // RULE21
endmodule // arm_remap
`default_nettype wire

// ==== sim/arm_remap_chk.sv ====
// Port-level assertions for the address remap block
`timescale 1ns/1ps
`default_nettype none
module arm_remap_chk #(
  parameter int NUM_DMA = 4,
  parameter logic [1:0] MAP_TYPE = arm_pkg::MAP_64,
  parameter logic [7:0] NEXT_PTR = 8'h00
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic isoc_fc_en,
  input wire arm_pkg::arm_cfg_req_t cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvld,
  input wire arm_pkg::arm_dn_req_t dn_req,
  input wire arm_pkg::arm_req_out_t dn_out,
  input wire arm_pkg::arm_up_req_t up_req,
  input wire arm_pkg::arm_req_out_t up_out,
  input wire logic [31:0] pnp_base_upper,
  input wire logic [31:0] pnp_limit_upper
);
  import arm_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence hdr_rd;
    cfg_req.rd && cfg_req.addr == OFF_HDR;
  endsequence
  // ==========================================================
  // Config port timing and header contents
  chk_rvld_pulse: assert property (cfg_req.rd |=> cfg_rvld)
    else $error("read strobe gave no read valid");
  chk_rvld_cause: assert property (cfg_rvld |-> $past(cfg_req.rd))
    else $error("read valid without a read");
  chk_rdata_hold: assert property (!cfg_req.rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");
  chk_hdr_fixed: assert property (hdr_rd |=> cfg_rdata[7:0] == CAP_ID && cfg_rdata[15:8] == NEXT_PTR)
    else $error("header id or pointer wrong");
  chk_hdr_kind: assert property (hdr_rd |=> cfg_rdata[31:27] == CAP_TYPE
    && cfg_rdata[26:25] == MAP_TYPE && cfg_rdata[19:16] == 4'(NUM_DMA))
    else $error("header type, map or count wrong");
  // ==========================================================
  // Datapath relations; a 1-cycle lag lets us tie outputs to causes
  chk_io_zero: assert property (dn_req.valid && dn_req.is_io |=> dn_out.valid && dn_out.addr[63:25] == '0)
    else $error("io address bits above 24 not zero");
  chk_dn_compat: assert property (dn_req.valid && dn_req.compat |=> dn_out.compat)
    else $error("compat attribute lost downstream");
  chk_up_pass: assert property (up_req.valid && up_req.in_dn_win |=>
    up_out.addr == $past(up_req.addr) && up_out.coherent == $past(up_req.coherent))
    else $error("request in a downstream window was altered");
  chk_up_coh: assert property (up_req.valid && !up_req.coherent |=> !up_out.coherent)
    else $error("coherent attribute set upstream");
  chk_vc_isoc: assert property (up_out.isoc_vc || dn_out.isoc_vc |-> $past(isoc_fc_en))
    else $error("isoc channel used without flow control");
  // ==========================================================
  // Main scenarios reached
  cover property (up_req.valid && !up_req.in_dn_win ##1 up_out.addr != $past(up_req.addr));
  cover property (dn_req.valid && dn_req.is_io);
  cover property (hdr_rd ##1 cfg_rvld);
endmodule // arm_remap_chk
bind arm_remap arm_remap_chk #(.NUM_DMA(NUM_DMA), .MAP_TYPE(MAP_TYPE), .NEXT_PTR(NEXT_PTR)) chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .isoc_fc_en(isoc_fc_en), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .cfg_rvld(cfg_rvld), .dn_req(dn_req), .dn_out(dn_out),
  .up_req(up_req), .up_out(up_out), .pnp_base_upper(pnp_base_upper),
  .pnp_limit_upper(pnp_limit_upper));
`default_nettype wire

// ==== sim/arm_sec_master.sv ====
// Secondary-bus requester that issues upstream cycles
`timescale 1ns/1ps
`default_nettype none
module arm_sec_master (
  input wire logic clk_sys,
  output var arm_pkg::arm_up_req_t up_req
);
  import arm_pkg::*;
  initial up_req = '0;
  // ==========================================================
  // One cycle per request; a released bus shows the inverse, not stale data
  task automatic send(input arm_up_req_t r);
    @(negedge clk_sys);
    up_req = r;
    @(negedge clk_sys);
    up_req = {1'b0, ~r[67:0]};
  endtask
endmodule // arm_sec_master
`default_nettype wire

// ==== sim/bridge_address_remap_test.sv ====
// Self-checking bench for the address remap block
`timescale 1ns/1ps
`default_nettype none
module bridge_address_remap_test;
  import arm_pkg::*;
  localparam int NDMA = 2;
  localparam logic [7:0] NPTR = 8'h40;
  localparam logic [63:0] WBASE = 64'h0000_0002_3000_0000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic isoc_fc_en = 1'b0;
  arm_cfg_req_t cfg_req = '0;
  arm_dn_req_t dn_req = '0;
  arm_up_req_t up_req;
  arm_req_out_t dn_out;
  arm_req_out_t up_out;
  logic [31:0] cfg_rdata, pbu, plu;
  logic cfg_rvld;
  logic [68:0] cq[$], dq[$], uq[$];
  logic [31:0] rnd = 32'hBB70;
  logic [4:0] sz[3] = '{5'h00, 5'h03, 5'h1F};
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  arm_remap #(.NUM_DMA(NDMA), .MAP_TYPE(MAP_64), .NEXT_PTR(NPTR)) dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .isoc_fc_en(isoc_fc_en), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvld(cfg_rvld), .dn_req(dn_req), .dn_out(dn_out), .up_req(up_req), .up_out(up_out),
    .pnp_base_upper(pbu), .pnp_limit_upper(plu));
  arm_sec_master far (.clk_sys(clk_sys), .up_req(up_req));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] hdr(input logic [4:0] s);
    return {CAP_TYPE, MAP_64, s, 4'(NDMA), NPTR, CAP_ID};
  endfunction
  function automatic arm_dn_req_t mkdn(input logic [2:0] k, input logic [63:0] a, off);
    return '{1'b1, k[2], k[1], k[0], a, off, 1'b0, 1'b1, 1'b0};
  endfunction
  task automatic chk(input string name, input logic [68:0] seen, input logic [68:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // A read notes its expected data; strobes stand one cycle
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    cfg_req = '{wr, !wr, a, 4'hF, d};
    if (!wr)
      cq.push_back(69'(d));
    @(negedge clk_sys);
    cfg_req = '0;
  endtask
  task automatic r64(input logic wr, input logic [7:0] idx, input logic [31:0] lo, hi);
    cfg(1'b1, OFF_INDEX, {24'h0, idx});
    cfg(wr, OFF_DLO, lo);
    cfg(wr, OFF_DHI, hi);
  endtask
  task automatic dn(input arm_dn_req_t r, input logic [68:0] e);
    @(negedge clk_sys);
    dn_req = r;
    dq.push_back(e);
    @(negedge clk_sys);
    dn_req.valid = 1'b0;
  endtask
  task automatic up(input logic [63:0] a, input logic inw, input logic [63:0] ea,
    input logic [3:0] at);
    uq.push_back({1'b1, ea, at});
    far.send('{1'b1, inw, a, 1'b0, 1'b1, 1'b0});
  endtask
  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================
  // Monitor takes the oldest note whenever a result appears
  always @(negedge clk_sys)
  begin
    if (rst_n && cfg_rvld === 1'b1)
      chk("cfg_rdata", 69'(cfg_rdata), cq.pop_front());
    if (rst_n && dn_out.valid === 1'b1)
      chk("dn_out", dn_out, dq.pop_front());
    if (rst_n && up_out.valid === 1'b1)
      chk("up_out", up_out, uq.pop_front());
  end
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      test_done();
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [63:0] a, off;
    logic [3:0] c;
    arm_dn_req_t d;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    cfg(1'b0, OFF_HDR, hdr(5'h00));
    cfg(1'b1, OFF_HDR, 32'hFFFF_FFFF);
    cfg(1'b0, OFF_HDR, hdr(5'h1F));
    cfg(1'b0, 8'h10, 32'h0);
    foreach (sz[i])
    begin
      cfg(1'b1, OFF_HDR, {7'h00, sz[i], 20'h0});
      rnd = lfsr(rnd);
      a = {rnd, ~rnd};
      dn(mkdn(3'b100, a, 64'h0),
        {1'b1, a & ((sz[i] >= 25) ? 64'h0 : (64'h1 << (25 - sz[i])) - 64'h1), 4'b0100});
    end
    // Compat asked by the requester survives an I/O cycle
    d = mkdn(3'b100, a, 64'h0);
    d.compat = 1'b1;
    dn(d, {1'b1, 64'h0, 4'b1100});
    $display("io size test done");
    // Every control nibble, flow control following the compat bit
    for (int i = 0; i < 16; i++)
    begin
      c = 4'(i);
      r64(1'b1, IDX_NP, {12'h300, 16'h0, c}, 32'h2);
      isoc_fc_en = c[0];
      rnd = lfsr(rnd);
      a = {32'h0, rnd};
      off = {44'h0, rnd[19:0]};
      dn(mkdn(3'b010, a, off), c[3] ? {1'b1, WBASE + off, c[0], !c[1], c[2], c[2] & c[0]}
        : {1'b1, a, 4'b0100});
    end
    r64(1'b0, IDX_NP, 32'h3000_000F, 32'h2);
    r64(1'b0, 8'h03, 32'h0, 32'h0);
    r64(1'b1, IDX_PF, 32'h5000_0008, 32'h0);
    dn(mkdn(3'b011, a, off), {1'b1, 64'h5000_0000 + off, 4'b0100});
    r64(1'b1, IDX_PNP, 32'h12, 32'h34);
    chk("pnp_upper", 69'({pbu, plu}), 69'h12_0000_0034);
    $display("downstream window test done");
    // Upstream: set 0 enabled with relaxed and isoc, set 1 disabled
    r64(1'b1, 8'h04, 32'hA000_000E, 32'h1);
    r64(1'b1, 8'h05, 32'h1000_0000, 32'h0);
    r64(1'b1, 8'h06, 32'h1010_0000, 32'h0);
    r64(1'b1, 8'h08, 32'hB000_0000, 32'h0);
    r64(1'b1, 8'h09, 32'h2000_0000, 32'h0);
    r64(1'b1, 8'h0A, 32'h2000_0000, 32'h0);
    r64(1'b0, 8'h04, 32'hA000_000E, 32'h1);
    up(64'h1000_0000, 1'b0, 64'h1_A000_0000, 4'b0011);
    up(64'h101F_FFFF, 1'b0, 64'h1_A01F_FFFF, 4'b0011);
    up(64'h1020_0000, 1'b0, 64'h1020_0000, 4'b0100);
    up(64'h0FFF_FFFF, 1'b0, 64'h0FFF_FFFF, 4'b0100);
    up(64'h1004_5678, 1'b1, 64'h1004_5678, 4'b0100);
    up(64'h2000_0040, 1'b0, 64'h2000_0040, 4'b0100);
    r64(1'b1, 8'h08, 32'hB000_0008, 32'h0);
    up(64'h2000_0040, 1'b0, 64'hB000_0040, 4'b0100);
    // A miss keeps a cleared coherent and a set compat as they came
    uq.push_back({1'b1, 64'h1020_0000, 4'b1000});
    far.send('{1'b1, 1'b0, 64'h1020_0000, 1'b1, 1'b0, 1'b0});
    $display("upstream window test done");
    // Warm reset in mid-run brings everything back
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    cfg(1'b0, OFF_HDR, hdr(5'h00));
    r64(1'b0, IDX_NP, 32'h0, 32'h0);
    r64(1'b0, 8'h04, 32'h0, 32'h0);
    repeat (4) @(negedge clk_sys);
    chk("pending", 69'(cq.size() + dq.size() + uq.size()), 69'h0);
    $display("warm reset test done");
    test_done();
  end
endmodule // bridge_address_remap_test
`default_nettype wire
